// *** core/seq_run_ctrl.sv ***
/*
 * Run control of a word-pattern generator: step clock selection, RUN /
 * STOP / BREAK sequencing, pattern memory, marker and channel outputs,
 * and an AXI4-Lite register slave.
 * Assumes one 40 MHz clock; the pattern pins are asynchronous to it.
 */
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module seq_run_ctrl
    import seq_run_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int ADDR_W = 14
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_clock_input,
    input wire logic run_gate_input,
    input wire logic stop_input,
    input wire logic pause_input,
    output logic [CHANNELS-1:0] data_out,
    output logic [CHANNELS-1:0] data_oe,
    output logic marker_out,
    output logic marker_oe,
    output logic first_clock_output,
    output logic first_clock_oe,
    output logic second_clock_output,
    output logic second_clock_oe
);
    localparam int NIN = 4;
    localparam int I_EXT = 0;
    localparam int I_RUN = 1;
    localparam int I_STOP = 2;
    localparam int I_PAUSE = 3;

    // Register state
    logic [31:0] control_q;
    logic [ADDR_W-1:0] first_addr_q;
    logic [ADDR_W-1:0] last_addr_q;
    logic [31:0] int_div_q;
    logic [31:0] chan_fmt_q;
    logic [15:0] rz_timing_q;
    logic [ADDR_W-1:0] pat_addr_q;
    logic [4:0] cmd_q;
    // Pattern memory: channel bits plus marker bit on top
    logic [CHANNELS:0] pattern_mem [2**ADDR_W];

    // Bus slave state
    logic aw_full_q;
    logic w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Sequencer state
    run_state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    logic finishing_q;
    logic gate_manual_q;
    logic stepped_q;
    logic [31:0] div_cnt_q;
    logic [7:0] rz_cnt_q;
    logic rz_live_q;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] lvl_q;
    logic [NIN-1:0] lvl_prev_q;

    clock_source_t src;
    cycle_mode_t mode;
    logic gated;
    logic preamble;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] fall;
    logic int_tick;
    logic ext_tick;
    logic src_tick;
    logic step_fwd;
    logic step_back;
    logic run_req;
    logic stop_req;
    logic pause_req;
    logic mark_break;
    logic do_write;
    logic [CHANNELS:0] word;
    logic [CHANNELS-1:0] rz_mask;

    // True when the configured edge has occurred on a filtered input
    function automatic logic edge_hit(input logic [1:0] cfg,
                                      input logic r, input logic f);
        edge_hit = (cfg == EDGE_RISE && r) || (cfg == EDGE_FALL && f);
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    assign src = clock_source_t'(control_q[CTL_SRC_LSB +: 2]);
    assign mode = cycle_mode_t'(control_q[CTL_MODE_LSB +: 3]);
    assign gated = (mode == CYC_GATED) || (mode == CYC_PRE_GATED);
    assign preamble = (mode == CYC_PRE_REPEAT) || (mode == CYC_PRE_GATED);
    assign rise = lvl_q & ~lvl_prev_q;
    assign fall = ~lvl_q & lvl_prev_q;
    assign word = pattern_mem[addr_q];
    assign rz_mask = chan_fmt_q[CHANNELS-1:0];

    // Three-stage synchroniser; a level counts once stages 2 and 3 agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
            lvl_prev_q <= '0;
        end
        else
        begin
            s1_q <= {pause_input, stop_input, run_gate_input,
                     external_clock_input};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NIN; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    lvl_q[i] <= s3_q[i];
                end
            end
            lvl_prev_q <= lvl_q;
        end
    end

    // Internal rate divider; 40 MHz caps the top of the range
    always_ff @(posedge aclk)
    begin
        if (!aresetn || div_cnt_q >= int_div_q)
        begin
            div_cnt_q <= '0;
        end
        else
        begin
            div_cnt_q <= div_cnt_q + 32'h0000_0001;
        end
    end

    // Step source selection
    always_comb
    begin
        int_tick = aresetn && (div_cnt_q >= int_div_q);
        ext_tick = (src == SRC_EXT_RISE) ? rise[I_EXT] :
                   fall[I_EXT];
        unique case (src)
            SRC_INTERNAL: src_tick = int_tick;
            SRC_EXT_RISE, SRC_EXT_FALL: src_tick = ext_tick;
            SRC_MANUAL: src_tick = 1'b0;
        endcase
        // Manual keys only in manual source; back only in break
        step_fwd = (src == SRC_MANUAL) && cmd_q[CMD_FWD] &&
                   (gated ? (state_q == ST_RUN && gate_manual_q)
                          : (state_q != ST_STOP));
        step_back = (src == SRC_MANUAL) && cmd_q[CMD_BACK] &&
                    !gated && state_q == ST_BREAK;
    end

    // Start, stop and pause requests
    always_comb
    begin
        stop_req = cmd_q[CMD_STOP] ||
                   edge_hit(control_q[CTL_STOP_LSB +: 2],
                            rise[I_STOP], fall[I_STOP]);
        if (gated)
        begin
            // Gate level rules; run key and all break sources dead
            run_req = lvl_q[I_RUN] && !finishing_q;
            pause_req = 1'b0;
            mark_break = 1'b0;
        end
        else
        begin
            run_req = cmd_q[CMD_RUN] ||
                      edge_hit(control_q[CTL_RUN_LSB +: 2],
                               rise[I_RUN], fall[I_RUN]);
            pause_req = cmd_q[CMD_PAUSE] ||
                        edge_hit(control_q[CTL_PAUSE_LSB +: 2],
                                 rise[I_PAUSE], fall[I_PAUSE]);
            // Checked on the word just stepped to, so resume is clean
            mark_break = stepped_q && control_q[CTL_MARK_PAUSE] &&
                         word[CHANNELS];
        end
    end

    // Operating state and address sequencing; stop beats pause beats run
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_STOP;
            addr_q <= '0;
            finishing_q <= 1'b0;
            gate_manual_q <= 1'b0;
            stepped_q <= 1'b0;
        end
        else
        begin
            stepped_q <= 1'b0;
            if (gated && state_q == ST_RUN && !lvl_q[I_RUN])
            begin
                finishing_q <= 1'b1;
                gate_manual_q <= 1'b0;
            end
            if (stop_req)
            begin
                state_q <= ST_STOP;
                finishing_q <= 1'b0;
                gate_manual_q <= 1'b0;
            end
            else if (pause_req && state_q == ST_RUN)
            begin
                state_q <= ST_BREAK;
            end
            else if (mark_break && state_q == ST_RUN)
            begin
                state_q <= ST_BREAK;
            end
            else if (run_req && state_q != ST_RUN)
            begin
                state_q <= ST_RUN;
                gate_manual_q <= gated && src == SRC_MANUAL;
                if (state_q == ST_STOP)
                begin
                    addr_q <= preamble ? '0 : first_addr_q;
                end
            end
            else if (step_back)
            begin
                addr_q <= addr_q - 1'b1;
                stepped_q <= 1'b1;
            end
            else if ((state_q == ST_RUN && (src_tick || step_fwd)) ||
                     (state_q == ST_BREAK && step_fwd))
            begin
                stepped_q <= 1'b1;
                if (state_q == ST_BREAK || addr_q != last_addr_q)
                begin
                    addr_q <= addr_q + 1'b1;
                end
                else if (mode == CYC_SINGLE || finishing_q)
                begin
                    state_q <= ST_STOP;
                    finishing_q <= 1'b0;
                end
                else
                begin
                    addr_q <= first_addr_q;
                end
            end
        end
    end

    // Return-to-zero window counted from each step
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rz_cnt_q <= '0;
            rz_live_q <= 1'b0;
        end
        else if (stepped_q)
        begin
            rz_cnt_q <= '0;
            rz_live_q <= 1'b1;
        end
        else if (rz_live_q)
        begin
            rz_cnt_q <= rz_cnt_q + 8'h01;
            if (rz_cnt_q >= rz_timing_q[7:0] + rz_timing_q[RZ_WIDTH_LSB +: 8])
            begin
                rz_live_q <= 1'b0;
            end
        end
    end

    // Registered pins; in stop NRZ channels just keep the last word
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_out <= '0;
            data_oe <= '0;
            marker_out <= 1'b0;
            marker_oe <= 1'b0;
            first_clock_output <= 1'b0;
            first_clock_oe <= 1'b0;
            second_clock_output <= 1'b0;
            second_clock_oe <= 1'b0;
        end
        else
        begin
            data_out <= ((word[CHANNELS-1:0] & ~rz_mask) |
                         (word[CHANNELS-1:0] & rz_mask &
                          {CHANNELS{rz_live_q &&
                                    rz_cnt_q >= rz_timing_q[7:0]}}))
                        ^ chan_fmt_q[FMT_COMPL_LSB +: CHANNELS];
            marker_out <= control_q[CTL_MARK_CLK] ? stepped_q
                                                  : word[CHANNELS];
            first_clock_output <= stepped_q || (state_q == ST_BREAK &&
                                  control_q[CTL_FIRST_CLOCK_OUTPUT_PAUSE] &&
                                  src_tick);
            second_clock_output <= stepped_q;
            data_oe <= {CHANNELS{control_q[CTL_OUT_ON]}};
            marker_oe <= control_q[CTL_OUT_ON];
            first_clock_oe <= control_q[CTL_OUT_ON];
            second_clock_oe <= control_q[CTL_OUT_ON];
        end
    end

    // Write address and data may arrive in either order
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q <= REG_PAT_DATA &&
                                aw_addr_q[1:0] == 2'b00 &&
                                aw_addr_q != REG_STATUS)
                               ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes; command bits live for exactly one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            control_q <= CONTROL_RESET;
            first_addr_q <= '0;
            last_addr_q <= '1;
            int_div_q <= '0;
            chan_fmt_q <= '0;
            rz_timing_q <= '0;
            pat_addr_q <= '0;
            cmd_q <= '0;
        end
        else
        begin
            cmd_q <= '0;
            if (do_write)
            begin
                unique case (aw_addr_q)
                    REG_CONTROL:
                        control_q <= merge(control_q, w_data_q, w_strb_q);
                    REG_FIRST_ADDR:
                        first_addr_q <= w_data_q[ADDR_W-1:0];
                    REG_LAST_ADDR:
                        last_addr_q <= w_data_q[ADDR_W-1:0];
                    REG_INT_DIVIDER:
                        int_div_q <= merge(int_div_q, w_data_q, w_strb_q);
                    REG_COMMAND:
                        cmd_q <= w_data_q[4:0];
                    REG_CHAN_FORMAT:
                        chan_fmt_q <= merge(chan_fmt_q, w_data_q, w_strb_q);
                    REG_RZ_TIMING:
                        rz_timing_q <= w_data_q[15:0];
                    REG_PAT_ADDR:
                        pat_addr_q <= w_data_q[ADDR_W-1:0];
                    REG_PAT_DATA:
                        pat_addr_q <= pat_addr_q + 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Pattern memory has no reset; software loads it before running
    always_ff @(posedge aclk)
    begin
        if (do_write && aw_addr_q == REG_PAT_DATA)
        begin
            pattern_mem[pat_addr_q] <= w_data_q[CHANNELS:0];
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CONTROL: s_axi_rdata <= control_q;
                REG_FIRST_ADDR: s_axi_rdata <= 32'(first_addr_q);
                REG_LAST_ADDR: s_axi_rdata <= 32'(last_addr_q);
                REG_INT_DIVIDER: s_axi_rdata <= int_div_q;
                REG_COMMAND: s_axi_rdata <= '0;
                REG_STATUS: s_axi_rdata <= 32'(state_q) |
                                           (32'(addr_q) << STAT_ADDR_LSB);
                REG_CHAN_FORMAT: s_axi_rdata <= chan_fmt_q;
                REG_RZ_TIMING: s_axi_rdata <= 32'(rz_timing_q);
                REG_PAT_ADDR: s_axi_rdata <= 32'(pat_addr_q);
                REG_PAT_DATA: s_axi_rdata <= 32'(pattern_mem[pat_addr_q]);
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// *** include/seq_run_pkg.sv ***
/*
 * Constants for the pattern sequencer run-control block: register map,
 * field positions, reset values, mode encodings and timing counts.
 * Assumes a single 40 MHz clock and an AXI4-Lite register bus.
 */
package seq_run_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_FIRST_ADDR = 8'h04;
    localparam logic [7:0] REG_LAST_ADDR = 8'h08;
    localparam logic [7:0] REG_INT_DIVIDER = 8'h0c;
    localparam logic [7:0] REG_COMMAND = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_CHAN_FORMAT = 8'h18;
    localparam logic [7:0] REG_RZ_TIMING = 8'h1c;
    localparam logic [7:0] REG_PAT_ADDR = 8'h20;
    localparam logic [7:0] REG_PAT_DATA = 8'h24;
    // Control field positions
    localparam int CTL_SRC_LSB = 0;
    localparam int CTL_MODE_LSB = 2;
    localparam int CTL_RUN_LSB = 5;
    localparam int CTL_STOP_LSB = 7;
    localparam int CTL_PAUSE_LSB = 9;
    localparam int CTL_MARK_CLK = 11;
    localparam int CTL_MARK_PAUSE = 12;
    localparam int CTL_FIRST_CLOCK_OUTPUT_PAUSE = 13;
    localparam int CTL_OUT_ON = 14;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // Command bits, each a one-shot on write
    localparam int CMD_RUN = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_PAUSE = 2;
    localparam int CMD_FWD = 3;
    localparam int CMD_BACK = 4;
    localparam int FMT_COMPL_LSB = 16;
    localparam int RZ_WIDTH_LSB = 8;
    localparam int STAT_ADDR_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXT_RISE, SRC_EXT_FALL,
                              SRC_MANUAL} clock_source_t;
    typedef enum logic [2:0] {CYC_REPEAT, CYC_SINGLE, CYC_GATED,
                              CYC_PRE_REPEAT, CYC_PRE_GATED} cycle_mode_t;
    typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL} edge_cfg_t;
    typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_BREAK} run_state_t;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int INT_MIN_HZ = 1;
    localparam int INT_MAX_HZ = 50_000_000;
    localparam int MARK_PULSE_NS = 8;
    localparam int MARK_PULSE_RAW = (MARK_PULSE_NS * (CLK_HZ / 1_000_000)
                                     + 999) / 1000;
    localparam int MARK_PULSE_CYC = (MARK_PULSE_RAW < 1) ? 1 : MARK_PULSE_RAW;
endpackage

// *** tb/seq_run_ctrl_asserts.sv ***
/* Port checker for seq_run_ctrl: bus answers, enables, step pulses.
   Bound to the design below; it sees only the top ports. */
module seq_run_ctrl_asserts #(
    parameter int CHANNELS = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CHANNELS-1:0] data_oe,
    input wire logic marker_oe,
    input wire logic first_clock_oe,
    input wire logic first_clock_output,
    input wire logic second_clock_output
);
    // One domain; reset masks every check
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken together, read address taken
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_rd_answer: assert property (s_rd_taken |=> !s_axi_arready
        ##[0:1] s_axi_rvalid) else $error("read answer late");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("read answer dropped");
    a_oe_together:
        assert property (data_oe == {CHANNELS{marker_oe}}
        && first_clock_oe == marker_oe) else $error("enables differ");
    a_oe_reset:
        assert property ($rose(aresetn) |-> !marker_oe && data_oe == '0)
        else $error("outputs driven after reset");
    a_step_pulse:
        assert property ($rose(second_clock_output) |=> !second_clock_output)
        else $error("step pulse too long");
    a_clk_pair:
        assert property (second_clock_output |-> first_clock_output)
        else $error("second clock without first");
endmodule

bind seq_run_ctrl seq_run_ctrl_asserts #(.CHANNELS(CHANNELS)) i_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .data_oe, .marker_oe,
    .first_clock_oe, .first_clock_output, .second_clock_output
);

// *** tb/seq_far_clock.sv ***
/* Far-side model: external step clock source at the pattern pins.
   The bench raises burst; the clock stands low between bursts. */
module seq_far_clock
(
    input wire logic burst,
    output logic external_clock_input
);
    timeunit 1ns;
    timeprecision 100ps;
    // Four slow periods, phase unrelated to the bench clock
    initial external_clock_input = 1'b0;
    always @(posedge burst)
    begin
        repeat (4)
        begin
            #113 external_clock_input = 1'b1;
            #137 external_clock_input = 1'b0;
        end
    end
endmodule

// *** tb/pattern_sequencer_run_control_tb.sv ***
/* Bench for seq_run_ctrl: bus master tasks, trigger pins, far clock.
   Assumes the default parameters and one 40 MHz clock. */
module pattern_sequencer_run_control_tb
    import seq_run_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, data_oe, data_out;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, burst = 1'b0;
    logic run_gate_input = 1'b0, stop_input = 1'b0, pause_input = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, external_clock_input, second_clock_output;
    logic marker_oe, marker_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count = 0, n_compared = 0;
    // Byte lanes always all enabled
    seq_run_ctrl i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .external_clock_input,
        .run_gate_input, .stop_input, .pause_input, .data_out,
        .data_oe, .marker_out, .marker_oe, .first_clock_output(),
        .first_clock_oe(), .second_clock_output, .second_clock_oe()
    );
    seq_far_clock i_far (.burst, .external_clock_input);
    initial forever #12.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // Both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            // Raised here so a back-to-back call still lowers, then raises
            if (!s_axi_bvalid) s_axi_bready <= 1'b1;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(e));
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (!s_axi_rvalid) s_axi_rready <= 1'b1;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
    endtask
    task automatic st(input run_state_t s, input logic [13:0] a);
        rd(REG_STATUS);
        chk(rv & 32'h003fff03, {10'h0, a, 6'h0, s});
    endtask
    task automatic cmd(input int b);
        wr(REG_COMMAND, 32'h1 << b, RESP_OKAY);
    endtask
    task automatic setc(input clock_source_t c, input cycle_mode_t m,
        input edge_cfg_t r, input edge_cfg_t s, input edge_cfg_t p);
        wr(REG_CONTROL, {18'h1, 3'h0, p, s, r, m, c}, RESP_OKAY);
    endtask
    // Pins change, then time for the synchroniser
    task automatic pins(input logic r, input logic s, input logic p);
        run_gate_input <= r;
        stop_input <= s;
        pause_input <= p;
        repeat (8) @(posedge aclk);
    endtask
    task automatic t_reset;
        chk(32'(data_oe), 32'h0);
        rd(REG_CONTROL);
        chk(rv, CONTROL_RESET);
        st(ST_STOP, 14'h0);
        rd(8'h28);
        chk(32'(s_axi_rresp), 32'(RESP_SLVERR));
        wr(REG_STATUS, 32'h1, RESP_SLVERR);
    endtask
    // Manual source, so only manual steps move the address; internal clock set slow
    task automatic t_break;
        setc(SRC_MANUAL, CYC_REPEAT, EDGE_OFF, EDGE_OFF, EDGE_OFF);
        wr(REG_FIRST_ADDR, 32'h5, RESP_OKAY);
        wr(REG_INT_DIVIDER, 32'h00ff_ffff, RESP_OKAY);
        cmd(CMD_RUN);
        st(ST_RUN, 14'h5);
        chk(32'(data_oe), 32'hff);
        cmd(CMD_PAUSE);
        cmd(CMD_FWD);
        cmd(CMD_FWD);
        cmd(CMD_BACK);
        st(ST_BREAK, 14'h6);
        cmd(CMD_RUN);
        st(ST_RUN, 14'h6);
        cmd(CMD_STOP);
        st(ST_STOP, 14'h6);
    endtask
    // Stopped word holds its NRZ value; complement flips chosen lanes
    task automatic t_data;
        wr(REG_PAT_ADDR, 32'h6, RESP_OKAY);
        wr(REG_PAT_DATA, 32'h1a5, RESP_OKAY);
        wr(REG_CHAN_FORMAT, 32'h00f0_0000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(data_out), 32'h55);
        chk(32'(marker_out), 32'h1);
    endtask
    task automatic t_pins;
        setc(SRC_INTERNAL, CYC_REPEAT, EDGE_RISE, EDGE_RISE, EDGE_FALL);
        pins(1'b1, 1'b0, 1'b1);
        st(ST_RUN, 14'h5);
        pins(1'b1, 1'b0, 1'b0);
        cmd(CMD_FWD);
        st(ST_BREAK, 14'h5);
        pins(1'b1, 1'b1, 1'b0);
        st(ST_STOP, 14'h5);
        pins(1'b0, 1'b0, 1'b1);
    endtask
    // Gate level rules; pause pin, run and pause commands have no effect
    task automatic t_gated;
        setc(SRC_INTERNAL, CYC_GATED, EDGE_RISE, EDGE_OFF, EDGE_FALL);
        cmd(CMD_RUN);
        st(ST_STOP, 14'h5);
        pins(1'b1, 1'b0, 1'b0);
        cmd(CMD_PAUSE);
        st(ST_RUN, 14'h5);
        pins(1'b0, 1'b0, 1'b0);
        cmd(CMD_STOP);
        st(ST_STOP, 14'h5);
    endtask
    // Four far clock periods give four steps on either edge
    task automatic t_ext;
        for (int i = 1; i < 3; i++)
        begin
            setc(clock_source_t'(i), CYC_REPEAT, EDGE_OFF, EDGE_OFF,
                EDGE_OFF);
            cmd(CMD_RUN);
            burst <= 1'b1;
            repeat (60) @(posedge aclk);
            burst <= 1'b0;
            st(ST_RUN, 14'h9);
            cmd(CMD_STOP);
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_break();
        t_data();
        t_pins();
        t_gated();
        t_ext();
        summarize();
    end
endmodule
